// *** pkg/epl_pkg.sv ***
// package: constants, carriers and state types of the serial eeprom protection logic
package epl_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W     = 13;          // used address bits
    localparam int unsigned PAGE_W     = 5;           // byte index inside a page
    localparam int unsigned PAGE_BYTES = 32;          // bytes per page
    localparam int unsigned ARRAY_BYTES = 8192;       // bytes in the array
    localparam logic [3:0]  ADDR_LAST_BIT = 4'hF;     // 16 address bits per command
    localparam logic [3:0]  BYTE_LAST_BIT = 4'h7;     // 8 bits per byte

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ  = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

    // ------------------------------------------------------------
    // status byte and protection ranges
    // ------------------------------------------------------------
    localparam logic [7:0]        STATUS_BUSY_VIEW = 8'hFF;  // shown while busy
    localparam logic [2:0]        STATUS_DC_BITS   = 3'h0;   // bits 6..4
    localparam int unsigned       SR_GUARD_PIN_ENABLE_BIT      = 7;      // guard enable position
    localparam int unsigned       SR_BP_HI         = 3;      // block guard high position
    localparam int unsigned       SR_BP_LO         = 2;      // block guard low position
    localparam logic [ADDR_W-1:0] GUARD_QUARTER    = 13'h1800;
    localparam logic [ADDR_W-1:0] GUARD_HALF       = 13'h1000;
    localparam logic [1:0]        GUARD_NONE       = 2'h0;
    localparam logic [1:0]        GUARD_Q          = 2'h1;
    localparam logic [1:0]        GUARD_H          = 2'h2;
    localparam logic              GUARD_PIN_ENABLE_RST         = 1'b0;   // power-up value
    localparam logic [1:0]        GUARD_RST        = 2'h0;   // power-up value

    // ------------------------------------------------------------
    // timing of the self-timed write cycle
    // ------------------------------------------------------------
    localparam int unsigned WRITE_TIME_US  = 5000;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
    localparam int unsigned WCNT_W         = 24;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;     // chip select, low selects
        logic sck;      // serial clock
        logic si;       // serial data in
        logic hold_n;   // pause, low pauses
        logic wp_n;     // write guard pin, low guards
    } epl_pins_s;

    // chip select resets low so that a real high-to-low is needed first
    localparam epl_pins_s PINS_RST = '{cs_n: 1'b0, sck: 1'b0, si: 1'b0,
                                       hold_n: 1'b1, wp_n: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_RD_DATA, ST_WR_DATA,
        ST_SR_RD, ST_SR_WR, ST_IGNORE
    } epl_state_e;

endpackage

// *** rtl/epl_eeprom_slave.sv ***
// module: serial eeprom command decoder, status register and write protection
module epl_eeprom_slave #(
    parameter int unsigned WRITE_CYCLES = epl_pkg::WRITE_CYCLES_DEF  // self-timed write length
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // serial pins from the host
    input  wire epl_pkg::epl_pins_s pins,
    // serial data out, push-pull released when not driving
    output logic                   so,
    output logic                   so_oe,
    // power state
    output logic                   standby
);
    import epl_pkg::*;

    // ------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------
    epl_pins_s p_lvl;   // stable levels
    epl_pins_s p_rise;  // one-cycle rising edges
    epl_pins_s p_fall;  // one-cycle falling edges

    epl_pin_sync #(
        .W       ($bits(epl_pins_s)),
        .RST_VAL (PINS_RST)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .d_async (pins),
        .lvl     (p_lvl),
        .rise    (p_rise),
        .fall    (p_fall)
    );

    // ------------------------------------------------------------
    // block state
    // ------------------------------------------------------------
    typedef struct packed {
        epl_state_e                       st;       // frame phase
        logic [3:0]                       bit_cnt;  // bit inside byte or address
        logic [7:0]                       in_sr;    // incoming byte
        logic [7:0]                       out_sr;   // outgoing byte
        logic                             so;       // serial output bit
        logic                             hold_act; // pause in force
        logic                             op_wr;    // address belongs to a write
        logic                             got;      // at least one data byte taken
        logic                             wp_fell;  // guard pin fell in this frame
        logic [ADDR_W-1:0]                addr;     // array address counter
        logic                             write_latch_flag;      // write enable latch
        logic                             guard_pin_enable;     // guard pin enable, nonvolatile
        logic [1:0]                       bp;       // block guard, nonvolatile
        logic                             busy;     // write cycle running
        logic [WCNT_W-1:0]                wcnt;     // remaining write cycle clocks
        logic [PAGE_W:0]                  walk;     // page commit index
        logic [ADDR_W-PAGE_W-1:0]         page_base;// page being written
        logic [PAGE_BYTES-1:0][7:0]       page;     // page buffer
        logic [PAGE_BYTES-1:0]            mask;     // buffered bytes to program
        logic [7:0]                       sr_new;   // pending status byte
        logic                             sr_pend;  // status write in the cycle
    } epl_core_s;

    epl_core_s q;
    epl_core_s next_q;

    // array storage and its write port
    logic [7:0]        mem [ARRAY_BYTES];
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0]        mem_wd;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [WCNT_W-1:0] wcnt_load;
    logic [7:0]        in_byte;      // byte completed by this rise
    logic [7:0]        status_view;  // status as shifted out
    logic              hw_guard;     // hardware protection active
    logic              run;          // frame live and not paused
    logic              addr_guarded; // current address is protected

    assign wcnt_load = WCNT_W'(WRITE_CYCLES - 1);
    assign in_byte   = {q.in_sr[6:0], p_lvl.si};

    // busy forces every bit to one, else layout of the status byte
    assign status_view = q.busy ? STATUS_BUSY_VIEW
                       : {q.guard_pin_enable, STATUS_DC_BITS, q.bp, q.write_latch_flag, q.busy};

    // guard pin level only counts when its enable bit is set
    assign hw_guard = q.guard_pin_enable & ~p_lvl.wp_n;

    // paused or deselected frames see no serial clock
    assign run = (q.st != ST_IDLE) & ~q.hold_act;

    // protected range from the block guard bits
    always_comb begin
        unique case (q.bp)
            GUARD_NONE: addr_guarded = 1'b0;
            GUARD_Q:    addr_guarded = (q.addr >= GUARD_QUARTER);
            GUARD_H:    addr_guarded = (q.addr >= GUARD_HALF);
            default:    addr_guarded = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        mem_we = 1'b0;
        mem_wa = {q.page_base, q.walk[PAGE_W-1:0]};
        mem_wd = q.page[q.walk[PAGE_W-1:0]];

        // self-timed write cycle: program buffered bytes while the counter counts out
        if (q.busy) begin
            if (q.walk < (PAGE_W+1)'(PAGE_BYTES)) begin
                mem_we      = q.mask[q.walk[PAGE_W-1:0]];
                next_q.walk = q.walk + 1'b1;
            end
            if (q.wcnt == '0) begin
                next_q.busy = 1'b0;
                next_q.write_latch_flag  = 1'b0;
                next_q.mask = '0;
                if (q.sr_pend) begin
                    // only enable and guard bits take the new value
                    next_q.guard_pin_enable = q.sr_new[SR_GUARD_PIN_ENABLE_BIT];
                    next_q.bp   = q.sr_new[SR_BP_HI:SR_BP_LO];
                end
                next_q.sr_pend = 1'b0;
            end else begin
                next_q.wcnt = q.wcnt - 1'b1;
            end
        end

        // pause is taken and left only while the serial clock is low
        if (~p_lvl.sck) begin
            next_q.hold_act = ~p_lvl.hold_n;
        end

        if (p_fall.cs_n) begin
            // a real high-to-low opens the frame; reset value blocks a false one
            next_q.st      = ST_OPCODE;
            next_q.bit_cnt = '0;
            next_q.got     = 1'b0;
            next_q.wp_fell = 1'b0;
            next_q.hold_act = 1'b0;
        end else if (p_rise.cs_n && q.st != ST_IDLE) begin
            // deselect ends the frame; writes start only on a byte boundary
            next_q.st = ST_IDLE;
            if (q.st == ST_WR_DATA && q.got && q.bit_cnt == '0
                && q.write_latch_flag && !q.busy) begin
                next_q.busy = 1'b1;
                next_q.wcnt = wcnt_load;
                next_q.walk = '0;
            end else if (q.st == ST_SR_WR && q.got && q.bit_cnt == '0
                         && q.write_latch_flag && !q.busy && !hw_guard
                         && !q.wp_fell) begin
                next_q.busy    = 1'b1;
                next_q.wcnt    = wcnt_load;
                next_q.walk    = (PAGE_W+1)'(PAGE_BYTES);
                next_q.sr_pend = 1'b1;
            end else if (q.st == ST_WR_DATA) begin
                next_q.mask = '0;
            end
        end else if (run) begin
            // guard pin fall while selected cancels a status write
            if (p_fall.wp_n) begin
                next_q.wp_fell = 1'b1;
            end

            // outgoing bit changes only after the falling clock
            if (p_fall.sck) begin
                next_q.so     = q.out_sr[7];
                next_q.out_sr = {q.out_sr[6:0], 1'b0};
            end

            // incoming bit taken on the rising clock
            if (p_rise.sck) begin
                next_q.in_sr = in_byte;
                next_q.bit_cnt = (q.bit_cnt == BYTE_LAST_BIT && q.st != ST_ADDR)
                               ? '0 : q.bit_cnt + 1'b1;
                unique case (q.st)
                    ST_OPCODE: begin
                        if (q.bit_cnt == BYTE_LAST_BIT) begin
                            next_q.st = ST_IGNORE;
                            // only status read is served during a write cycle
                            unique case (in_byte)
                                OP_LATCH_SET: begin
                                    if (!q.busy) next_q.write_latch_flag = 1'b1;
                                end
                                OP_LATCH_CLEAR: begin
                                    if (!q.busy) next_q.write_latch_flag = 1'b0;
                                end
                                OP_STATUS_READ: begin
                                    next_q.st     = ST_SR_RD;
                                    next_q.out_sr = status_view;
                                end
                                OP_STATUS_WRITE: begin
                                    if (!q.busy) next_q.st = ST_SR_WR;
                                end
                                OP_ARRAY_READ, OP_ARRAY_WRITE: begin
                                    if (!q.busy) next_q.st = ST_ADDR;
                                    next_q.op_wr = (in_byte == OP_ARRAY_WRITE);
                                end
                                default: next_q.st = ST_IGNORE;
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        // sixteen bits shift through; only the low ones remain
                        next_q.addr = {q.addr[ADDR_W-2:0], p_lvl.si};
                        if (q.bit_cnt == ADDR_LAST_BIT) begin
                            next_q.bit_cnt = '0;
                            if (q.op_wr) begin
                                next_q.st        = ST_WR_DATA;
                                next_q.mask      = '0;
                                next_q.page_base = q.addr[ADDR_W-2:PAGE_W-1];
                            end else begin
                                next_q.st     = ST_RD_DATA;
                                next_q.out_sr = mem[{q.addr[ADDR_W-2:0], p_lvl.si}];
                                next_q.addr   = {q.addr[ADDR_W-2:0], p_lvl.si} + 1'b1;
                            end
                        end
                    end
                    ST_RD_DATA: begin
                        // next byte loads; counter rolls from top to zero
                        if (q.bit_cnt == BYTE_LAST_BIT) begin
                            next_q.out_sr = mem[q.addr];
                            next_q.addr   = q.addr + 1'b1;
                        end
                    end
                    ST_SR_RD: begin
                        // status repeats while the clock keeps running
                        if (q.bit_cnt == BYTE_LAST_BIT) begin
                            next_q.out_sr = status_view;
                        end
                    end
                    ST_WR_DATA: begin
                        if (q.bit_cnt == BYTE_LAST_BIT) begin
                            next_q.got = 1'b1;
                            // protected bytes are dropped, never buffered
                            if (!addr_guarded) begin
                                next_q.page[q.addr[PAGE_W-1:0]] = in_byte;
                                next_q.mask[q.addr[PAGE_W-1:0]] = 1'b1;
                            end
                            // low bits wrap inside the page
                            next_q.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + 1'b1;
                        end
                    end
                    ST_SR_WR: begin
                        if (q.bit_cnt == BYTE_LAST_BIT) begin
                            next_q.got    = 1'b1;
                            next_q.sr_new = in_byte;
                        end
                    end
                    ST_IGNORE, ST_IDLE: begin
                        next_q.st = q.st;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers; reset stands for power-up, latch starts cleared
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q           <= '0;
            q.st        <= ST_IDLE;
            q.write_latch_flag       <= 1'b0;
            q.guard_pin_enable      <= GUARD_PIN_ENABLE_RST;
            q.bp        <= GUARD_RST;
            q.walk      <= (PAGE_W+1)'(PAGE_BYTES);
        end else begin
            q <= next_q;
        end
    end

    // array storage keeps its content across reset, like the cells
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // output released when deselected, paused or not in a read phase
    assign so      = q.so;
    assign so_oe   = run & ((q.st == ST_RD_DATA) | (q.st == ST_SR_RD));
    // standby only when deselected and no write cycle runs
    assign standby = (q.st == ST_IDLE) & ~q.busy;

endmodule

// *** rtl/epl_pin_sync.sv ***
// module: two-flop synchroniser with edge detection for the serial pins
module epl_pin_sync #(
    parameter int unsigned          W       = 5,
    parameter logic [W-1:0]         RST_VAL = '0
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // asynchronous pins
    input  wire logic [W-1:0]       d_async,
    // synchronised level and edges
    output logic      [W-1:0]       lvl,
    output logic      [W-1:0]       rise,
    output logic      [W-1:0]       fall
);

    // ------------------------------------------------------------
    // state: first stage, second stage, edge history
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;   // metastable stage, read only by s2
        logic [W-1:0] s2;   // stable level
        logic [W-1:0] s3;   // previous stable level
    } epl_sync_s;

    epl_sync_s q;
    epl_sync_s next_q;

    // shift every pin one stage per clock
    always_comb begin
        next_q.s1 = d_async;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
    end

    // reset to the RST_VAL pin levels, never to a port value
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
        end else begin
            q <= next_q;
        end
    end

    // edges compare only the stable stages
    assign lvl  = q.s2;
    assign rise = q.s2 & ~q.s3;
    assign fall = ~q.s2 & q.s3;

endmodule

// *** tb/epl_eeprom_slave_assertions.sv ***
// checker: port-level timing relations of the serial eeprom slave
module epl_eeprom_slave_assertions (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire epl_pkg::epl_pins_s pins,
    input wire logic               so,
    input wire logic               so_oe,
    input wire logic               standby
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // pins pass a synchroniser, so each relation but a_oe_start allows a few clocks of lag
    a_desel_release: assert property (pins.cs_n [*6] |-> !so_oe)
        else $error("so driven while deselected");
    a_sel_active: assert property ($fell(pins.cs_n) |-> ##[1:6] !standby)
        else $error("standby kept while selected");
    a_standby_rise: assert property ($rose(standby) |-> $past(pins.cs_n, 3))
        else $error("standby entered while selected");
    a_hold_release: assert property (!pins.hold_n [*6] |-> !so_oe)
        else $error("so driven during pause");
    a_oe_start: assert property ($rose(so_oe) |-> !pins.cs_n && pins.hold_n)
        else $error("so enabled outside a frame");
    a_oe_sel: assert property (so_oe |-> !$past(pins.cs_n, 6))
        else $error("so enabled late after deselect");
    a_so_fall: assert property (so_oe && $changed(so) |-> !$past(pins.sck, 2))
        else $error("so changed away from clock fall");
    a_so_stable: assert property (so_oe && $past(so_oe) && pins.sck && $past(pins.sck, 2)
        |-> $stable(so))
        else $error("so moved while clock high");
endmodule

// *** tb/epl_eeprom_slave_bench.sv ***
// self-checking bench of the serial eeprom protection logic
module epl_eeprom_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import epl_pkg::*;
    logic        clk_sys;
    logic        sys_rst;
    epl_pins_s   pins;
    logic        so;
    logic        so_oe;
    logic        standby;
    logic        so_line;
    logic [63:0] rx;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // short write cycle, yet long enough for a status read to land inside it
    epl_eeprom_slave #(.WRITE_CYCLES(200)) epl_eeprom_slave_inst (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .pins(pins), .so(so), .so_oe(so_oe), .standby(standby));
    // a released output shows the inverse, so a read outside the drive window fails
    assign so_line = so_oe ? so : ~so;
    epl_host_model epl_host_model_inst (.clk_sys(clk_sys), .pins(pins), .so(so_line));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // watchdog against a hung frame
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [63:0] tx, input int n);
        epl_host_model_inst.xfer(tx, n, -1, rx);
    endtask
    task automatic wt();
        repeat (250) @(posedge clk_sys);
    endtask
    task automatic stat(input logic [7:0] e);
        run(64'h0500, 16);
        chk(rx[7:0], e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        run({8'h03, a, 16'h0000}, 40);
        chk(rx[15:0], e);
    endtask
    task automatic wrb(input logic [15:0] a, input logic [7:0] d);
        run(8'h06, 8);
        run({8'h02, a, d}, 32);
        wt();
    endtask
    task automatic t_latch();
        stat(8'h00);
        run(8'h06, 8);
        stat(8'h02);
        run(8'h04, 8);
        stat(8'h00);
        $display("latch test done");
    endtask
    task automatic t_status();
        run(8'h06, 8);
        run(16'h01FF, 16);
        chk({15'h0000, standby}, 16'h0000);
        stat(8'hFF);
        wt();
        chk({15'h0000, standby}, 16'h0001);
        stat(8'h8C);
        $display("status test done");
    endtask
    task automatic t_guard();
        epl_host_model_inst.guard(1'b0);
        run(8'h06, 8);
        run(16'h0100, 16);
        stat(8'h8E);
        epl_host_model_inst.guard(1'b1);
        run(16'h0100, 16);
        wt();
        stat(8'h00);
        $display("guard test done");
    endtask
    task automatic t_array();
        run(8'h06, 8);
        run({8'h02, 16'hE03F, 24'h112233}, 48);
        wt();
        rd(16'h0020, 16'h2233);
        wrb(16'h1FFF, 8'h33);
        wrb(16'h0000, 8'h44);
        rd(16'h1FFF, 16'h3344);
        $display("array test done");
    endtask
    task automatic t_protect();
        run(8'h06, 8);
        run(16'h0104, 16);
        wt();
        stat(8'h04);
        wrb(16'h1FFF, 8'h77);
        rd(16'h1FFF, 16'h3344);
        run(8'h06, 8);
        run(16'h010C, 16);
        wt();
        stat(8'h0C);
        wrb(16'h0000, 8'h55);
        rd(16'h1FFF, 16'h3344);
        run(8'h06, 8);
        run(16'h0100, 16);
        wt();
        $display("protect test done");
    endtask
    task automatic t_hold();
        run(8'h06, 8);
        epl_host_model_inst.xfer(64'h0500, 16, 3, rx);
        chk(rx[7:0], 8'h02);
        $display("hold test done");
    endtask
    task automatic t_cancel();
        run(8'h06, 8);
        run({8'h02, 16'h0000, 12'hABC}, 36);
        wt();
        run({8'h03, 16'h0000, 8'h00}, 32);
        chk(rx[7:0], 8'h44);
        stat(8'h02);
        run(8'h04, 8);
        run({8'h02, 16'h0000, 8'h99}, 32);
        wt();
        rd(16'h1FFF, 16'h3344);
        $display("cancel test done");
    endtask
    initial begin
        sys_rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        // chip select must be seen high before its first fall can open a frame
        epl_host_model_inst.tick(4);
        t_latch();
        t_status();
        t_guard();
        t_array();
        t_protect();
        t_hold();
        t_cancel();
        close_out();
    end
endmodule
bind epl_eeprom_slave epl_eeprom_slave_assertions epl_eeprom_slave_assertions_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins), .so(so), .so_oe(so_oe),
    .standby(standby));

// *** tb/epl_host_model.sv ***
// host serial controller model: drives the device pins, mode 0
module epl_host_model (
    // clock
    input  wire logic         clk_sys,
    // device pins
    output epl_pkg::epl_pins_s pins,
    input  wire logic         so
);
    timeunit 1ns;
    timeprecision 1ps;
    // select idles high so the first frame shows a real fall
    initial pins = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    // move n clocks on, just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // write guard pin level
    task automatic guard(input logic v);
        pins.wp_n = v;
    endtask
    // one frame of n bits msb first; pause before bit hold_at
    task automatic xfer(input logic [63:0] tx, input int n, input int hold_at,
                        output logic [63:0] rx);
        rx = '0;
        pins.cs_n = 1'b0;
        tick(5);
        for (int i = n - 1; i >= 0; i--) begin
            pins.si = tx[i];
            if (i == hold_at) begin
                pins.hold_n = 1'b0;
                tick(5);
                // a clock pulse during the pause must not move the sequence
                pins.sck = 1'b1;
                tick(5);
                pins.sck = 1'b0;
                tick(10);
                pins.hold_n = 1'b1;
                tick(5);
            end
            tick(5);
            rx = {rx[62:0], so};
            pins.sck = 1'b1;
            tick(5);
            pins.sck = 1'b0;
        end
        tick(5);
        pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        tick(8);
    endtask
endmodule
